// [core/nvm_parallel_programming_port.sv]
/*
 * Parallel programming port: command, address and data latches, erase,
 * program and read of flash, EEPROM, lock bits and fuse bits.
 * Assumes all pins are synchronous to core_clk and that mode entry and
 * serial programming enable are decided outside and shown on prog_enable.
 */
`default_nettype none
`include "nvm_port_cfg.svh"
module nvm_parallel_programming_port #(
   parameter int         PROG_CYCLES = `PROG_CYCLES,
   parameter logic [7:0] SIG_BYTE0   = 8'h5a,  // Arbitrary identification value.
   parameter logic [7:0] SIG_BYTE1   = 8'h3c,  // Arbitrary identification value.
   parameter logic [7:0] SIG_BYTE2   = 8'h24   // Arbitrary identification value.
) (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic       prog_enable,
   input  wire logic       serial_mode,
   input  wire logic       oscillator_input_pin,
   input  wire logic       action_select_high,
   input  wire logic       action_select_low,
   input  wire logic       byte_half_select,
   input  wire logic       wr_n,
   input  wire logic       oe_n,
   input  wire logic [7:0] prog_data_bus_in,
   output var  logic [7:0] prog_data_bus_out,
   output var  logic       prog_data_bus_oe,
   output logic            ready_busy_flag,
   output var  logic       serial_download_fuse,
   output var  logic       short_startup_fuse,
   output var  logic       lock_bit_one,
   output var  logic       lock_bit_two
);

   // ----------------------------------------------------------------------
   // State and storage
   // ----------------------------------------------------------------------
   nvm_port_pkg::state_e      state;       // Current operation.
   logic [16:0]               timer;       // Programming time counter.
   logic [`FLASH_AW-1:0]      erase_cnt;   // Erase walk position.
   logic                      lock_armed;  // Lock release requested.
   logic [7:0]                cmd;         // Loaded command byte.
   logic [7:0]                addr_lo;     // Loaded low address byte.
   logic [7:0]                addr_hi;     // Loaded high address byte.
   logic [7:0]                data;        // Loaded data byte.
   logic                      osc_prev;    // Oscillator pin, last cycle.
   logic                      wr_prev;     // Write strobe, last cycle.
   logic [7:0]                flash_lo [0:(1<<`FLASH_AW)-1];  // Flash low bytes.
   logic [7:0]                flash_hi [0:(1<<`FLASH_AW)-1];  // Flash high bytes.
   logic [7:0]                eeprom   [0:(1<<`EE_AW)-1];     // EEPROM bytes.

   // ----------------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------------
   wire       osc_rise   = oscillator_input_pin & ~osc_prev;
   wire       wr_fall    = ~wr_n & wr_prev;
   wire [1:0] act        = {action_select_high, action_select_low};
   // Code 11 matches none of these, so a pulse then changes nothing.
   wire       load_cmd   = osc_rise && act == `ACT_CMD && !byte_half_select; // [RL1] [RL23]
   wire       load_addr  = osc_rise && act == `ACT_ADDR;  // [RL11] [RL23]
   wire       load_data  = osc_rise && act == `ACT_DATA;  // [RL12] [RL23]
   wire       to_ee      = cmd[0];                        // [RL2] [RL3]
   wire       is_wr_mem  = cmd[7:1] == `CMD_WRITE_MEM;    // [RL2] [RL15]
   wire       is_rd_mem  = cmd[7:1] == `CMD_READ_MEM;
   wire       is_fuse    = cmd == `CMD_WRITE_FUSE;
   wire       is_lock    = cmd == `CMD_WRITE_LOCK;
   // A programmed lock one bars memory writes; both programmed bar verify too.
   wire       write_bar  = ~lock_bit_one;
   wire       verify_bar = ~lock_bit_one & ~lock_bit_two;
   // Address spaces are cut to their own widths.
   wire [`FLASH_AW-1:0] fl_addr = {addr_hi[3:0], addr_lo};  // [RL21]
   wire [`EE_AW-1:0]    ee_addr = {addr_hi[0], addr_lo};    // [RL21]
   // Nothing is written or erased before programming is enabled.
   wire       start_write = wr_fall && state == nvm_port_pkg::ST_IDLE && prog_enable
                           && ((is_wr_mem && !write_bar) || is_fuse || is_lock); // [RL19] [RL13]
   wire       start_erase = load_cmd && prog_data_bus_in == `CMD_CHIP_ERASE
                           && prog_enable && state == nvm_port_pkg::ST_IDLE;     // [RL1] [RL19]
   wire       prog_done  = timer == 17'(PROG_CYCLES - 1);
   wire       erase_done = erase_cnt == {`FLASH_AW{1'b1}};

   // Ready only falls for programming; erase leaves it high.
   assign ready_busy_flag = state != nvm_port_pkg::ST_PROG;  // [RL24] [RL10] [RL13]

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   wire [7:0] fl_byte  = byte_half_select ? flash_hi[fl_addr] : flash_lo[fl_addr];
   wire [7:0] ee_byte  = eeprom[ee_addr];
   wire [7:0] fl_byte_seen = verify_bar ? `ERASED_BYTE : fl_byte;
   wire [7:0] ee_byte_seen = verify_bar ? `ERASED_BYTE : ee_byte;
   wire [7:0] fuse_lock_byte = {lock_bit_one, lock_bit_two, serial_download_fuse,
                                4'h0, short_startup_fuse};  // [RL7]
   wire [7:0] sig_byte = addr_lo == 8'h00 ? SIG_BYTE0 :
                         addr_lo == 8'h01 ? SIG_BYTE1 :
                         addr_lo == 8'h02 ? SIG_BYTE2 : 8'h00;  // [RL18]
   wire       rd_fl    = is_rd_mem && !to_ee;                   // [RL16]
   wire       rd_ee    = is_rd_mem && to_ee && !byte_half_select;            // [RL17]
   wire       rd_sig   = cmd == `CMD_READ_SIG && !byte_half_select;          // [RL18]
   wire       rd_fuse  = cmd == `CMD_READ_FUSELOCK && byte_half_select;      // [RL7]
   wire       next_bus_oe  = !oe_n && (rd_fl || rd_ee || rd_sig || rd_fuse);
   wire [7:0] next_bus_out = rd_fl  ? fl_byte_seen :
                             rd_ee  ? ee_byte_seen :
                             rd_sig ? sig_byte :
                             rd_fuse ? fuse_lock_byte : 8'h00;

   // ----------------------------------------------------------------------
   // Latches, bus driver and edge history
   // ----------------------------------------------------------------------
   // Command and address stay until reloaded, so runs need no reload.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cmd               <= 8'h00;
         addr_lo           <= 8'h00;
         addr_hi           <= 8'h00;
         data              <= `ERASED_BYTE;
         osc_prev          <= 1'b0;
         wr_prev           <= 1'b1;
         prog_data_bus_out <= 8'h00;
         prog_data_bus_oe  <= 1'b0;
      end else if (ce) begin
         osc_prev          <= oscillator_input_pin;
         wr_prev           <= wr_n;
         prog_data_bus_out <= next_bus_out;
         prog_data_bus_oe  <= next_bus_oe;
         if (load_cmd) begin
            cmd <= prog_data_bus_in;  // [RL1] [RL14]
         end
         if (load_addr && byte_half_select) begin
            addr_hi <= prog_data_bus_in;  // [RL11] [RL14]
         end else if (load_addr) begin
            addr_lo <= prog_data_bus_in;  // [RL11] [RL14]
         end
         if (load_data) begin
            data <= prog_data_bus_in;  // [RL12]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Operation sequencer, fuses and lock bits
   // ----------------------------------------------------------------------
   // Idle takes writes and erases; program times out; erase walks arrays.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state                <= nvm_port_pkg::ST_IDLE;
         timer                <= 17'h00000;
         erase_cnt            <= {`FLASH_AW{1'b0}};
         lock_armed           <= 1'b0;
         serial_download_fuse <= `SERIAL_FUSE_RST;
         short_startup_fuse   <= `START_FUSE_RST;
         lock_bit_one         <= `LOCK_RST;
         lock_bit_two         <= `LOCK_RST;
      end else if (ce) begin
         case (state)
            nvm_port_pkg::ST_IDLE: begin
               timer <= 17'h00000;
               if (start_erase) begin
                  state      <= nvm_port_pkg::ST_ERASE;
                  erase_cnt  <= {`FLASH_AW{1'b0}};
                  lock_armed <= 1'b0;
               end else if (start_write) begin
                  state <= nvm_port_pkg::ST_PROG;
                  if (is_fuse) begin
                     serial_download_fuse <= data[`FUSE_SERIAL_BIT];  // [RL4]
                     short_startup_fuse   <= data[`FUSE_START_BIT];   // [RL4]
                  end
                  if (is_lock) begin
                     // A lock bit can only move toward programmed here.
                     lock_bit_one <= lock_bit_one & data[`LOCK_ONE_BIT];  // [RL5] [RL6]
                     lock_bit_two <= lock_bit_two & data[`LOCK_TWO_BIT];  // [RL5] [RL6]
                  end
               end
            end
            nvm_port_pkg::ST_PROG: begin
               timer <= timer + 17'h00001;  // [RL13]
               if (prog_done) begin
                  state <= nvm_port_pkg::ST_IDLE;
               end
            end
            nvm_port_pkg::ST_ERASE: begin
               erase_cnt <= erase_cnt + {{(`FLASH_AW-1){1'b0}}, 1'b1};
               if (wr_fall) begin
                  lock_armed <= 1'b1;  // [RL10]
               end
               if (erase_done) begin
                  state <= nvm_port_pkg::ST_IDLE;
                  // Locks release only once the arrays are fully erased.
                  if (lock_armed || wr_fall) begin
                     lock_bit_one <= 1'b1;  // [RL9] [RL6]
                     lock_bit_two <= 1'b1;  // [RL9] [RL6]
                  end
               end
            end
            default: begin
               state <= nvm_port_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Array writes
   // ----------------------------------------------------------------------
   // Parallel writes only clear bits, so flash must be erased first.
   always_ff @(posedge core_clk) begin
      if (ce && !reset) begin
         if (state == nvm_port_pkg::ST_ERASE) begin
            flash_lo[erase_cnt]           <= `ERASED_BYTE;  // [RL9] [RL20]
            flash_hi[erase_cnt]           <= `ERASED_BYTE;  // [RL9] [RL20]
            eeprom[erase_cnt[`EE_AW-1:0]] <= `ERASED_BYTE;  // [RL9] [RL20]
         end else if (start_write && is_wr_mem && to_ee) begin
            eeprom[ee_addr] <= serial_mode ? data : (ee_byte & data);  // [RL15] [RL20]
         end else if (start_write && is_wr_mem && byte_half_select) begin
            flash_hi[fl_addr] <= flash_hi[fl_addr] & data;  // [RL2] [RL13] [RL9]
         end else if (start_write && is_wr_mem) begin
            flash_lo[fl_addr] <= flash_lo[fl_addr] & data;  // [RL2] [RL13] [RL9]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_cmd_load: assert property (@(posedge core_clk) disable iff (reset)  // [RL1]
      ce && load_cmd |=> cmd == $past(prog_data_bus_in))
      else $error("command byte not loaded");
   a_idle_action: assert property (@(posedge core_clk) disable iff (reset)  // [RL23]
      ce && act == 2'b11 |=> $stable(cmd) && $stable(addr_lo) && $stable(data))
      else $error("idle action changed a latch");
   a_busy_start: assert property (@(posedge core_clk) disable iff (reset)  // [RL13]
      ce && start_write |=> !ready_busy_flag ##1 (!ready_busy_flag || !ce))
      else $error("ready flag did not drop on write");
   a_erase_quiet: assert property (@(posedge core_clk) disable iff (reset)  // [RL10]
      state == nvm_port_pkg::ST_ERASE |=> ready_busy_flag
         && (state == nvm_port_pkg::ST_ERASE || $past(erase_done)))
      else $error("ready flag moved or erase cut short");
   a_lock_release: assert property (@(posedge core_clk) disable iff (reset)  // [RL6]
      $rose(lock_bit_one) |-> $past(state) == nvm_port_pkg::ST_ERASE && $past(erase_done))
      else $error("lock bit released outside erase end");
   a_fuse_write: assert property (@(posedge core_clk) disable iff (reset)  // [RL4]
      ce && start_write && is_fuse |=> serial_download_fuse == $past(data[5])
         && short_startup_fuse == $past(data[0]))
      else $error("fuse bits not written from data");
   a_fuse_read: assert property (@(posedge core_clk) disable iff (reset)  // [RL7]
      ce && !oe_n && rd_fuse |=> prog_data_bus_oe
         && prog_data_bus_out == {$past(lock_bit_one), $past(lock_bit_two),
            $past(serial_download_fuse), 4'h0, $past(short_startup_fuse)})
      else $error("fuse and lock read wrong");
   a_sig_read: assert property (@(posedge core_clk) disable iff (reset)  // [RL18]
      ce && !oe_n && rd_sig && addr_lo == 8'h01 |=> prog_data_bus_out == SIG_BYTE1)
      else $error("identification byte wrong");
   a_no_enable: assert property (@(posedge core_clk) disable iff (reset)  // [RL19]
      !prog_enable && state == nvm_port_pkg::ST_IDLE |=> state == nvm_port_pkg::ST_IDLE)
      else $error("operation started without enable");

endmodule : nvm_parallel_programming_port
`default_nettype wire

// [shared/nvm_port_cfg.svh]
/*
 * Constants of the parallel programming port: command codes, action codes,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock and inclusion before the port module.
 */
// Overview of operation
// RL1 - Action 10 pulse loads command; 80 erases
// RL2 - Command 10 programs flash; bit 0 selects
// RL3 - Command bit 0: flash zero, EEPROM one
// RL4 - Command 40 writes fuses from data bits
// RL5 - Command 20 programs locks from data bits
// RL6 - Only chip erase releases programmed lock bits
// RL7 - Command 04 reads locks and fuses, select high
// RL8 - Programmer holds reset, select low before entry
// RL9 - Erase clears arrays, locks after; fuses kept
// RL10 - Strobe during erase arms lock release; quiet
// RL11 - Action 00 pulse loads low/high address byte
// RL12 - Action 01 pulse loads the data byte
// RL13 - Write strobe programs byte; busy until done
// RL14 - Command and address kept across programming
// RL15 - Command 11 programs one EEPROM byte
// RL16 - Command 02 reads flash byte by select
// RL17 - Command 03 reads the addressed EEPROM byte
// RL18 - Command 08 reads identification byte 0..2
// RL19 - Serial mode needs programming enable first
// RL20 - Serial EEPROM write auto erases; erase FF
// RL21 - Flash 0000..0FFF and EEPROM 0000..01FF spaces
// RL22 - Programmer keeps serial clock phases over two
// RL23 - Action 11 pulse does nothing at all
// RL24 - Ready flag low while programming, else high
`ifndef NVM_PORT_CFG_SVH
`define NVM_PORT_CFG_SVH

// ----------------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------------
`define CMD_CHIP_ERASE     8'h80
`define CMD_WRITE_FUSE     8'h40
`define CMD_WRITE_LOCK     8'h20
`define CMD_WRITE_MEM      7'h08
`define CMD_READ_SIG       8'h08
`define CMD_READ_FUSELOCK  8'h04
`define CMD_READ_MEM       7'h01

// ----------------------------------------------------------------------
// Action select codes
// ----------------------------------------------------------------------
`define ACT_ADDR           2'b00
`define ACT_DATA           2'b01
`define ACT_CMD            2'b10

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define FUSE_SERIAL_BIT    5
`define FUSE_START_BIT     0
`define LOCK_TWO_BIT       2
`define LOCK_ONE_BIT       1
`define FLASH_AW           12
`define EE_AW              9

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define ERASED_BYTE        8'hff
`define SERIAL_FUSE_RST    1'b0
`define START_FUSE_RST     1'b1
`define LOCK_RST           1'b1
`define CLK_PERIOD_NS      10
`define PROG_TIME_NS       700000
`define PROG_CYCLES        (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// [shared/nvm_port_pkg.sv]
/*
 * Types shared by the parallel programming port.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package nvm_port_pkg;
   // Operation states, Gray coded along idle, program, erase.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_PROG  = 2'b01,
      ST_ERASE = 2'b11
   } state_e;
endpackage : nvm_port_pkg
`default_nettype wire

// [test/nvm_programmer.sv]
/*
 * Programmer model for the parallel programming port: drives mode entry,
 * latch pulses, write strobes and output enable, and resolves the data bus.
 * Assumes the port and this model share one free-running core clock.
 */
`default_nettype none
module nvm_programmer (
   input  wire logic       core_clk,
   input  wire logic [7:0] prog_data_bus_out,
   input  wire logic       prog_data_bus_oe,
   output wire logic [7:0] prog_data_bus,
   output logic            prog_enable,
   output logic            oscillator_input_pin,
   output logic            action_select_high,
   output logic            action_select_low,
   output logic            byte_half_select,
   output logic            wr_n,
   output logic            oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] drv;    // Last byte the programmer drove.
   logic       drive;  // High while the programmer owns the bus.
   // A released bus shows the inverse of the last byte, so stale data cannot pass.
   assign prog_data_bus = prog_data_bus_oe ? prog_data_bus_out : (drive ? drv : ~drv);
   // Idle levels at time zero: strobes inactive, select low.
   initial begin
      drv = 8'h00;
      drive = 1'b0;
      prog_enable = 1'b0;
      oscillator_input_pin = 1'b0;
      {action_select_high, action_select_low} = 2'b11;
      byte_half_select = 1'b0;
      wr_n = 1'b1;
      oe_n = 1'b1;
   end
   // Enters programming mode with the select held quiet around the enable.
   task automatic enter_mode();
      byte_half_select <= 1'b0;
      repeat (10) @(posedge core_clk);
      // Enable stands in for serial entry too, so no short serial clock phase exists.
      prog_enable <= 1'b1;
      repeat (10) @(posedge core_clk);
   endtask : enter_mode
   // Loads one byte: the action code picks address, data, command or nothing.
   task automatic latch(input logic [1:0] a, input logic b, input logic [7:0] d);
      @(posedge core_clk);
      {action_select_high, action_select_low} <= a;
      byte_half_select <= b;
      drv <= d;
      drive <= 1'b1;
      oscillator_input_pin <= 1'b1;
      @(posedge core_clk);
      oscillator_input_pin <= 1'b0;
      drive <= 1'b0;
   endtask : latch
   // Gives the write strobe one low cycle with the byte select set.
   task automatic strobe(input logic b);
      @(posedge core_clk);
      byte_half_select <= b;
      wr_n <= 1'b0;
      @(posedge core_clk);
      wr_n <= 1'b1;
   endtask : strobe
   // Enables the output for one sample, taken once the registered data settles.
   task automatic read(input logic b, output logic [7:0] d);
      @(posedge core_clk);
      byte_half_select <= b;
      oe_n <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      d = prog_data_bus;
      @(posedge core_clk);
      oe_n <= 1'b1;
   endtask : read
endmodule : nvm_programmer
`default_nettype wire

// [test/nvm_parallel_programming_port_bench.sv]
/*
 * Self-checking bench for the parallel programming port.
 * Assumes the programmer model drives every pin the port listens to except core_clk, reset, ce and serial_mode.
 */
`default_nettype none
module nvm_parallel_programming_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         PROG = 8;      // Shortened programming time.
   localparam logic [7:0] SIG0 = 8'h11;  // Arbitrary identification value.
   localparam logic [7:0] SIG1 = 8'h22;  // Arbitrary identification value.
   localparam logic [7:0] SIG2 = 8'h33;  // Arbitrary identification value.
   logic       core_clk, reset, ce, serial_mode, prog_enable, oscillator_input_pin;
   logic       action_select_high, action_select_low, byte_half_select, wr_n, oe_n;
   logic       prog_data_bus_oe, ready_busy_flag, serial_download_fuse;
   logic       short_startup_fuse, lock_bit_one, lock_bit_two;
   logic [7:0] prog_data_bus, prog_data_bus_out, rnd, lo, hi, d0, d1, rd;
   int         errors, check_count, n;
   always #5 core_clk = ~core_clk;
   nvm_parallel_programming_port #(.PROG_CYCLES(PROG), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
      .SIG_BYTE2(SIG2)) u_nvm_parallel_programming_port (.core_clk, .reset, .ce,
      .prog_enable, .serial_mode, .oscillator_input_pin, .action_select_high,
      .action_select_low, .byte_half_select, .wr_n, .oe_n, .prog_data_bus_in(prog_data_bus),
      .prog_data_bus_out, .prog_data_bus_oe, .ready_busy_flag, .serial_download_fuse,
      .short_startup_fuse, .lock_bit_one, .lock_bit_two);
   nvm_programmer u_nvm_programmer (.core_clk, .prog_data_bus_out, .prog_data_bus_oe,
      .prog_data_bus, .prog_enable, .oscillator_input_pin, .action_select_high,
      .action_select_low, .byte_half_select, .wr_n, .oe_n);
   // --------------------------------------------------------------------
   // Expectation functions and shared tasks
   // --------------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic [7:0] sig_exp(input int i);
      return (i == 0) ? SIG0 : (i == 1) ? SIG1 : (i == 2) ? SIG2 : 8'h00;
   endfunction : sig_exp
   function automatic logic [7:0] fuse_byte(input logic l1, l2, sf, st);
      return {l1, l2, sf, 4'h0, st};
   endfunction : fuse_byte
   // Compares and counts; a mismatch is reported at once.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Strobes a write and counts the busy cycles that follow.
   task automatic write_byte(input logic b, input int exp_cycles);
      u_nvm_programmer.strobe(b);
      n = 0;
      @(negedge core_clk);
      while (ready_busy_flag === 1'b0 && n < 100) begin
         n++;
         @(negedge core_clk);
      end
      check(16'(n), 16'(exp_cycles));
   endtask : write_byte
   // Chip erase with the lock release armed; the ready flag must stay high.
   task automatic erase();
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h80);
      u_nvm_programmer.strobe(1'b0);
      @(negedge core_clk);
      check(16'(ready_busy_flag), 16'h0001);
      repeat (4100) @(posedge core_clk);
   endtask : erase
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out
   // --------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      reset = 1'b1;
      serial_mode = 1'b0;
      ce = 1'b1;
      errors = 0;
      check_count = 0;
      rnd = 8'h3d;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      @(negedge core_clk);
      check(16'({ready_busy_flag, serial_download_fuse, short_startup_fuse, lock_bit_one,
         lock_bit_two, prog_data_bus_oe}), 16'h002e);
      u_nvm_programmer.enter_mode();
      // A latch pulse while the clock enable is low must load nothing.
      ce <= 1'b0;
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h04);
      ce <= 1'b1;
      u_nvm_programmer.read(1'b1, rd);
      check(16'(rd), 16'h00fb);
      // Identification bytes, including the first address past them.
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h08);
      for (int i = 0; i < 4; i++) begin
         u_nvm_programmer.latch(2'b00, 1'b0, 8'(i));
         u_nvm_programmer.read(1'b0, rd);
         check(16'(rd), 16'(sig_exp(i)));
      end
      erase();
      // Flash low and high byte at a random word; command and address kept.
      rnd = lfsr(rnd);
      lo = rnd;
      rnd = lfsr(rnd);
      hi = (rnd & 8'h0f) | 8'h02;
      rnd = lfsr(rnd);
      d0 = rnd;
      rnd = lfsr(rnd);
      d1 = rnd;
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h10);
      u_nvm_programmer.latch(2'b00, 1'b0, lo);
      u_nvm_programmer.latch(2'b00, 1'b1, hi);
      u_nvm_programmer.latch(2'b01, 1'b0, d0);
      write_byte(1'b0, PROG);
      u_nvm_programmer.latch(2'b01, 1'b1, d1);
      write_byte(1'b1, PROG);
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h02);
      u_nvm_programmer.read(1'b0, rd);
      check(16'(rd), 16'(d0));
      u_nvm_programmer.read(1'b1, rd);
      check(16'(rd), 16'(d1));
      // EEPROM byte at the top page; an idle pulse must change nothing.
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h11);
      u_nvm_programmer.latch(2'b00, 1'b1, 8'h01);
      u_nvm_programmer.latch(2'b01, 1'b0, d0);
      write_byte(1'b0, PROG);
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h03);
      u_nvm_programmer.latch(2'b11, 1'b0, 8'h02);
      u_nvm_programmer.read(1'b0, rd);
      check(16'(rd), 16'(d0));
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h02);
      u_nvm_programmer.read(1'b0, rd);
      check(16'(rd), 16'h00ff);
      // Serial mode write replaces the byte outright.
      serial_mode <= 1'b1;
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h11);
      u_nvm_programmer.latch(2'b01, 1'b0, ~d0);
      write_byte(1'b0, PROG);
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h03);
      u_nvm_programmer.read(1'b0, rd);
      check(16'(rd), {8'h00, ~d0});
      serial_mode <= 1'b0;
      // Fuses, then lock one; a later all-ones lock write must not release it.
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h40);
      u_nvm_programmer.latch(2'b01, 1'b0, 8'h3e);
      write_byte(1'b0, PROG);
      check(16'({serial_download_fuse, short_startup_fuse}), 16'h0002);
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h20);
      u_nvm_programmer.latch(2'b01, 1'b0, 8'hfd);
      write_byte(1'b0, PROG);
      u_nvm_programmer.latch(2'b01, 1'b0, 8'hff);
      write_byte(1'b0, PROG);
      check(16'({lock_bit_one, lock_bit_two}), 16'h0001);
      // A programmed lock one refuses a memory write, so no busy time follows.
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h11);
      write_byte(1'b0, 0);
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h04);
      u_nvm_programmer.read(1'b1, rd);
      check(16'(rd), 16'(fuse_byte(1'b0, 1'b1, 1'b1, 1'b0)));
      // Chip erase releases the locks, keeps the fuses and blanks the EEPROM.
      erase();
      check(16'({lock_bit_one, lock_bit_two, serial_download_fuse, short_startup_fuse}),
         16'h000e);
      u_nvm_programmer.latch(2'b10, 1'b0, 8'h03);
      u_nvm_programmer.read(1'b0, rd);
      check(16'(rd), 16'h00ff);
      close_out();
   end
   // Watchdog: the sequence needs about 8400 cycles.
   initial begin
      repeat (30000) @(posedge core_clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
endmodule : nvm_parallel_programming_port_bench
`default_nettype wire
